//--- hw/sacc_top.sv
// Conversion control for a 12-bit successive-approximation converter
`timescale 1ns/1ps
`default_nettype none
`include "sacc_regs.svh"

module sacc_top
    import sacc_pkg::*;
(
    input wire logic clock,
    input wire logic arst_n,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr_en,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata_q,
    input wire logic timer2_ovf,
    input wire logic timer3_ovf,
    input wire logic ext_convert_start,
    input wire logic cmp_in,
    input wire logic chip_sleep,
    input wire logic irq_en,
    output logic conv_irq_q,
    output logic conv_busy_q,
    output logic analog_enable_q,
    output logic track_q,
    output logic [11:0] sar_code_q,
    output logic [2:0] mux_channel_q,
    output logic mux_diff_q,
    output logic temp_sel_q,
    output logic [2:0] gain_q
);

    // ----------------------------------------------------------------
    // Reset release and input synchronisers
    // ----------------------------------------------------------------
    logic [1:0] rst_sync_q;
    logic rst_n;
    logic [1:0] async_in;
    logic [1:0] sync1_q;
    logic [1:0] sync2_q;
    logic ext_s;
    logic cmp_s;
    logic ext_prev_q;
    logic ext_rise;
    // Synchronisers reset to the idle pin levels, so no false edge
    localparam logic [1:0] SyncRst = `SACC_RST_SYNC;

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    assign async_in = {cmp_in, ext_convert_start};

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_sync
            always_ff @(posedge clock or negedge rst_n) begin
                if (!rst_n) begin
                    sync1_q[gi] <= SyncRst[gi];
                    sync2_q[gi] <= SyncRst[gi];
                end else begin
                    sync1_q[gi] <= async_in[gi];
                    sync2_q[gi] <= sync1_q[gi];
                end
            end
        end
    endgenerate
    assign ext_s = sync2_q[0];
    assign cmp_s = sync2_q[1];

    // Edge taken from the second stage only
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ext_prev_q <= 1'b1;
        end else begin
            ext_prev_q <= ext_s;
        end
    end
    assign ext_rise = ext_s & ~ext_prev_q;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic [15:0] sacc_format(input logic [11:0] code,
                                                input logic diff,
                                                input logic ljst);
        logic [11:0] val;
        val = code;
        if (diff) begin
            val[11] = ~code[11];
        end
        if (ljst) begin
            sacc_format = {val, 4'h0};
        end else begin
            sacc_format = {{4{diff & val[11]}}, val};
        end
    endfunction

    function automatic logic sacc_is_diff(input logic [3:0] pairs,
                                          input logic [3:0] chan);
        sacc_is_diff = ~chan[3] & pairs[chan[2:1]];
    endfunction

    // ----------------------------------------------------------------
    // Register file
    // ----------------------------------------------------------------
    logic [3:0] pair_cfg_q, pair_cfg_d;
    logic [3:0] chan_sel_q, chan_sel_d;
    logic [7:0] conv_cfg_q, conv_cfg_d;
    logic [7:0] ctrl_q, ctrl_d;
    logic [7:0] res_hi_q, res_hi_d;
    logic [7:0] res_lo_q, res_lo_d;
    logic [7:0] rdata_d;
    logic [11:0] code_d;
    logic wr_ctrl;
    logic sw_start;
    logic done_set;
    logic busy;
    logic [15:0] result_fmt;
    logic [4:0] divider;
    logic conv_en;
    logic low_power_trk;
    sacc_src_t src;

    assign wr_ctrl = sfr_wr_en && (sfr_addr == `SACC_ADDR_CONV_CTRL);
    assign divider = conv_cfg_q[`SACC_CFG_DIV_HI:`SACC_CFG_DIV_LO];
    assign conv_en = ctrl_q[`SACC_CTRL_EN];
    assign low_power_trk = ctrl_q[`SACC_CTRL_TM];
    assign src = sacc_src_t'(ctrl_q[`SACC_CTRL_CM_HI:`SACC_CTRL_CM_LO]);
    // Written and stored mode bits must both be software, and stored enable is needed, so one write cannot select and start;
    // a write that disables never starts, avoiding a one-cycle busy blip
    assign sw_start = wr_ctrl && sfr_wdata[`SACC_CTRL_BUSY]
        && sfr_wdata[`SACC_CTRL_EN]
        && (sfr_wdata[`SACC_CTRL_CM_HI:`SACC_CTRL_CM_LO] == SACC_SRC_SW);
    // Next code, so the last decided bit is in the stored result
    assign result_fmt = sacc_format(code_d,
        sacc_is_diff(pair_cfg_q, chan_sel_q), ctrl_q[`SACC_CTRL_LJST]);

    always_comb begin
        pair_cfg_d = pair_cfg_q;
        chan_sel_d = chan_sel_q;
        conv_cfg_d = conv_cfg_q;
        ctrl_d = ctrl_q;
        res_hi_d = res_hi_q;
        res_lo_d = res_lo_q;
        if (sfr_wr_en) begin
            case (sfr_addr)
                `SACC_ADDR_PAIR_CFG: pair_cfg_d = sfr_wdata[3:0];
                `SACC_ADDR_CHAN_SEL: chan_sel_d = sfr_wdata[3:0];
                `SACC_ADDR_CONV_CFG: conv_cfg_d = sfr_wdata;
                `SACC_ADDR_RES_HIGH: res_hi_d = sfr_wdata;
                `SACC_ADDR_RES_LOW: res_lo_d = sfr_wdata;
                `SACC_ADDR_CONV_CTRL: ctrl_d = sfr_wdata;
                default: ctrl_d = ctrl_q;
            endcase
        end
        // Busy is state, not storage; the write-one effect is sw_start
        ctrl_d[`SACC_CTRL_BUSY] = 1'b0;
        if (done_set) begin
            ctrl_d[`SACC_CTRL_DONE] = 1'b1;
            res_hi_d = result_fmt[15:8];
            res_lo_d = result_fmt[7:0];
        end
        rdata_d = 8'h00;
        case (sfr_addr)
            `SACC_ADDR_PAIR_CFG: rdata_d = {4'h0, pair_cfg_q};
            `SACC_ADDR_CHAN_SEL: rdata_d = {4'h0, chan_sel_q};
            `SACC_ADDR_CONV_CFG: rdata_d = conv_cfg_q;
            `SACC_ADDR_RES_HIGH: rdata_d = res_hi_q;
            `SACC_ADDR_RES_LOW: rdata_d = res_lo_q;
            `SACC_ADDR_CONV_CTRL: begin
                rdata_d = ctrl_q;
                rdata_d[`SACC_CTRL_BUSY] = busy;
            end
            default: rdata_d = 8'h00;
        endcase
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pair_cfg_q <= 4'(`SACC_RST_PAIR_CFG);
            chan_sel_q <= 4'(`SACC_RST_CHAN_SEL);
            conv_cfg_q <= `SACC_RST_CONV_CFG;
            ctrl_q <= `SACC_RST_CONV_CTRL;
            res_hi_q <= `SACC_RST_RESULT;
            res_lo_q <= `SACC_RST_RESULT;
            sfr_rdata_q <= 8'h00;
        end else begin
            pair_cfg_q <= pair_cfg_d;
            chan_sel_q <= chan_sel_d;
            conv_cfg_q <= conv_cfg_d;
            ctrl_q <= ctrl_d;
            res_hi_q <= res_hi_d;
            res_lo_q <= res_lo_d;
            sfr_rdata_q <= rdata_d;
        end
    end

    // ----------------------------------------------------------------
    // SAR clock divider
    // ----------------------------------------------------------------
    logic [5:0] div_cnt_q, div_cnt_d;
    logic sar_tick;
    sacc_state_t state_q, state_d;

    // Held in reload while idle so tracking counts whole SAR periods
    always_comb begin
        div_cnt_d = div_cnt_q;
        sar_tick = 1'b0;
        if (state_q == SACC_IDLE || divider == 5'h00) begin
            div_cnt_d = {divider, 1'b1};
            sar_tick = (divider == 5'h00);
        end else if (div_cnt_q == 6'h00) begin
            div_cnt_d = {divider, 1'b1};
            sar_tick = 1'b1;
        end else begin
            div_cnt_d = div_cnt_q - 6'h01;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            div_cnt_q <= 6'h00;
        end else begin
            div_cnt_q <= div_cnt_d;
        end
    end

    // ----------------------------------------------------------------
    // Conversion sequencer
    // ----------------------------------------------------------------
    localparam int MinGap = `SACC_MIN_CONV_CYC;
    logic [1:0] trk_q, trk_d;
    logic [3:0] bit_q, bit_d;
    logic [1:0] settle_q, settle_d;
    logic [7:0] gap_q, gap_d;
    logic start_evt;
    logic start_ok;

    always_comb begin
        case (src)
            SACC_SRC_SW: start_evt = sw_start;
            SACC_SRC_T3: start_evt = timer3_ovf;
            SACC_SRC_EXT: start_evt = ext_rise;
            SACC_SRC_T2: start_evt = timer2_ovf;
            default: start_evt = 1'b0;
        endcase
    end
    // Early triggers are dropped rather than queued
    assign start_ok = conv_en && start_evt && (gap_q == 8'h00);

    always_comb begin
        state_d = state_q;
        trk_d = trk_q;
        bit_d = bit_q;
        code_d = sar_code_q;
        settle_d = settle_q;
        gap_d = gap_q;
        done_set = 1'b0;
        if (gap_q != 8'h00) begin
            gap_d = gap_q - 8'h01;
        end
        if (settle_q != 2'h0) begin
            settle_d = settle_q - 2'h1;
        end
        case (state_q)
            SACC_IDLE: begin
                if (start_ok) begin
                    gap_d = 8'(MinGap - 1);
                    if (low_power_trk && src != SACC_SRC_EXT) begin
                        state_d = SACC_TRACK;
                        trk_d = 2'(`SACC_TRACK_SAR_CLKS - 1);
                    end else begin
                        state_d = SACC_CONV;
                        bit_d = 4'(`SACC_RES_BITS - 1);
                        code_d = 12'h800;
                        settle_d = 2'(`SACC_CMP_SETTLE);
                    end
                end
            end
            SACC_TRACK: begin
                if (sar_tick) begin
                    if (trk_q == 2'h0) begin
                        state_d = SACC_CONV;
                        bit_d = 4'(`SACC_RES_BITS - 1);
                        code_d = 12'h800;
                        settle_d = 2'(`SACC_CMP_SETTLE);
                    end else begin
                        trk_d = trk_q - 2'h1;
                    end
                end
            end
            SACC_CONV: begin
                // Wait for the synchronised comparator to see the trial
                if (sar_tick && settle_q == 2'h0) begin
                    code_d[bit_q] = cmp_s;
                    if (bit_q == 4'h0) begin
                        state_d = SACC_IDLE;
                        done_set = 1'b1;
                    end else begin
                        bit_d = bit_q - 4'h1;
                        code_d[bit_q - 4'h1] = 1'b1;
                        settle_d = 2'(`SACC_CMP_SETTLE);
                    end
                end
            end
            default: state_d = SACC_IDLE;
        endcase
        if (!conv_en) begin
            state_d = SACC_IDLE;
            done_set = 1'b0;
        end
    end

    assign busy = (state_q != SACC_IDLE);

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= SACC_IDLE;
            trk_q <= 2'h0;
            bit_q <= 4'h0;
            sar_code_q <= 12'h000;
            settle_q <= 2'h0;
            gap_q <= 8'h00;
        end else begin
            state_q <= state_d;
            trk_q <= trk_d;
            bit_q <= bit_d;
            sar_code_q <= code_d;
            settle_q <= settle_d;
            gap_q <= gap_d;
        end
    end

    // ----------------------------------------------------------------
    // Analog front-end controls
    // ----------------------------------------------------------------
    logic track_d;
    logic irq_d;

    always_comb begin
        track_d = 1'b0;
        if (conv_en && !chip_sleep) begin
            case (state_q)
                SACC_IDLE: begin
                    if (!low_power_trk) begin
                        track_d = 1'b1;
                    end else if (src == SACC_SRC_EXT) begin
                        track_d = ~ext_s;
                    end
                end
                SACC_TRACK: track_d = 1'b1;
                default: track_d = 1'b0;
            endcase
        end
        irq_d = ctrl_d[`SACC_CTRL_DONE] && irq_en;
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            track_q <= 1'b0;
            conv_irq_q <= 1'b0;
            conv_busy_q <= 1'b0;
            analog_enable_q <= 1'b0;
            mux_channel_q <= 3'h0;
            mux_diff_q <= 1'b0;
            temp_sel_q <= 1'b0;
            gain_q <= 3'h0;
        end else begin
            track_q <= track_d;
            conv_irq_q <= irq_d;
            conv_busy_q <= (state_d != SACC_IDLE);
            analog_enable_q <= conv_en;
            temp_sel_q <= chan_sel_q[3];
            mux_diff_q <= sacc_is_diff(pair_cfg_q, chan_sel_q);
            if (sacc_is_diff(pair_cfg_q, chan_sel_q)) begin
                mux_channel_q <= {chan_sel_q[2:1], 1'b0};
            end else begin
                mux_channel_q <= chan_sel_q[2:0];
            end
            gain_q <= conv_cfg_q[`SACC_CFG_GAIN_HI:0];
        end
    end

endmodule // sacc_top

`default_nettype wire

//--- hw/sacc_regs.svh
// Register addresses, field positions, reset values and timing counts
`ifndef SACC_REGS_SVH
`define SACC_REGS_SVH

`define SACC_ADDR_PAIR_CFG 8'hBA
`define SACC_ADDR_CHAN_SEL 8'hBB
`define SACC_ADDR_CONV_CFG 8'hBC
`define SACC_ADDR_RES_LOW 8'hBE
`define SACC_ADDR_RES_HIGH 8'hBF
`define SACC_ADDR_CONV_CTRL 8'hE8

`define SACC_RST_PAIR_CFG 8'h00
`define SACC_RST_CHAN_SEL 8'h00
`define SACC_RST_CONV_CFG 8'hF8
`define SACC_RST_CONV_CTRL 8'h00
`define SACC_RST_RESULT 8'h00
// Start pin idles high, comparator low: bit0 start, bit1 comparator
`define SACC_RST_SYNC 2'h1

`define SACC_CTRL_EN 7
`define SACC_CTRL_TM 6
`define SACC_CTRL_DONE 5
`define SACC_CTRL_BUSY 4
`define SACC_CTRL_CM_HI 3
`define SACC_CTRL_CM_LO 2
`define SACC_CTRL_WFLAG 1
`define SACC_CTRL_LJST 0
`define SACC_CFG_DIV_HI 7
`define SACC_CFG_DIV_LO 3
`define SACC_CFG_GAIN_HI 2

`define SACC_CLK_KHZ 25000
`define SACC_MAX_RATE_KSPS 100
`define SACC_MIN_CONV_CYC (`SACC_CLK_KHZ / `SACC_MAX_RATE_KSPS)
`define SACC_TRACK_SAR_CLKS 3
`define SACC_RES_BITS 12
`define SACC_CMP_SETTLE 2

`endif

//--- hw/sacc_pkg.sv
// Types shared by the converter control block
package sacc_pkg;
    typedef enum logic [2:0] {
        SACC_IDLE = 3'h1,
        SACC_TRACK = 3'h2,
        SACC_CONV = 3'h4
    } sacc_state_t;

    typedef enum logic [1:0] {
        SACC_SRC_SW = 2'h0,
        SACC_SRC_T3 = 2'h1,
        SACC_SRC_EXT = 2'h2,
        SACC_SRC_T2 = 2'h3
    } sacc_src_t;
endpackage

//--- dv/sacc_checker.sv
// Port-level assertions for the converter control block
`timescale 1ns/1ps
`default_nettype none
module sacc_checker (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic chip_sleep,
    input wire logic irq_en,
    input wire logic conv_irq_q,
    input wire logic conv_busy_q,
    input wire logic analog_enable_q,
    input wire logic track_q,
    input wire logic [2:0] mux_channel_q,
    input wire logic mux_diff_q,
    input wire logic temp_sel_q
);
    logic prev_q, prev_d, rise;
    logic [7:0] gap_q, gap_d;
    // ----
    // Cycles since the last start, saturating so idle time never wraps
    // ----
    assign rise = conv_busy_q && !prev_q;
    always_comb begin
        prev_d = conv_busy_q;
        gap_d = (gap_q == 8'hFF) ? gap_q : gap_q + 8'h01;
        if (rise) begin
            gap_d = 8'h01;
        end
    end
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            prev_q <= 1'b0;
            gap_q <= 8'hFF;
        end else begin
            prev_q <= prev_d;
            gap_q <= gap_d;
        end
    end
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!arst_n);
    AST_START_GAP: assert property (rise |-> gap_q >= 8'hFA)
        else $error("start too soon");
    AST_BUSY_HOLD: assert property (rise |=> conv_busy_q [*8])
        else $error("busy dropped early");
    AST_DONE_IRQ: assert property ($fell(conv_busy_q) && analog_enable_q
        && irq_en |-> ##[0:2] conv_irq_q) else $error("no interrupt");
    AST_IRQ_CAUSE: assert property (conv_irq_q |-> $past(irq_en))
        else $error("interrupt while disabled");
    AST_OFF_IDLE: assert property (!analog_enable_q ##1 !analog_enable_q
        |-> !conv_busy_q && !track_q) else $error("active while off");
    AST_SLEEP_OFF: assert property (chip_sleep ##1 chip_sleep
        |-> !track_q) else $error("tracking in sleep");
    AST_TEMP_SE: assert property (temp_sel_q |-> !mux_diff_q)
        else $error("sensor marked differential");
    AST_DIFF_EVEN: assert property (mux_diff_q |-> !mux_channel_q[0])
        else $error("pair not on even input");
    COV_START: cover property (rise);
    COV_IRQ: cover property (conv_irq_q);
    COV_DIFF: cover property (mux_diff_q);
endmodule // sacc_checker
bind sacc_top sacc_checker chk_u (.clock(clock), .arst_n(arst_n),
    .chip_sleep(chip_sleep), .irq_en(irq_en), .conv_irq_q(conv_irq_q),
    .conv_busy_q(conv_busy_q), .analog_enable_q(analog_enable_q),
    .track_q(track_q), .mux_channel_q(mux_channel_q),
    .mux_diff_q(mux_diff_q), .temp_sel_q(temp_sel_q));
`default_nettype wire

//--- dv/sacc_partner.sv
// Timer overflow, external start pin and comparator model
`timescale 1ns/1ps
`default_nettype none
module sacc_partner (
    input wire logic clock,
    input wire logic [11:0] sar_code_q,
    output logic timer2_ovf,
    output logic timer3_ovf,
    output logic ext_convert_start,
    output logic cmp_in
);
    logic [11:0] level;
    // Start pin idles high: open-drain line released to its pull-up
    initial begin
        timer2_ovf = 1'b0;
        timer3_ovf = 1'b0;
        ext_convert_start = 1'b1;
        level = 12'h000;
    end
    // Ideal comparator, so the final code must equal the level
    assign cmp_in = level >= sar_code_q;
    task automatic ovf(input logic t3);
        timer3_ovf = t3;
        timer2_ovf = !t3;
        @(negedge clock);
        timer3_ovf = 1'b0;
        timer2_ovf = 1'b0;
    endtask
    task automatic pin(input logic lvl);
        ext_convert_start = lvl;
    endtask
endmodule // sacc_partner
`default_nettype wire

//--- dv/tb.sv
// Self-checking bench for the converter control block
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clock, arst_n, sfr_wr_en, chip_sleep, irq_en, tm, lj;
    logic [7:0] sfr_addr, sfr_wdata, sfr_rdata_q, v, hi;
    logic timer2_ovf, timer3_ovf, ext_convert_start, cmp_in;
    logic conv_irq_q, conv_busy_q, analog_enable_q, track_q;
    logic mux_diff_q, temp_sel_q;
    logic [2:0] mux_channel_q, gain_q;
    logic [11:0] sar_code_q;
    logic [31:0] lfsr;
    int failures, total_checks, n_len, n_fast;
    logic [7:0] ra [7] = '{8'hBA, 8'hBB, 8'hBC, 8'hE8, 8'hBE, 8'hBF, 8'h00};
    logic [7:0] rv [7] = '{8'h00, 8'h00, 8'hF8, 8'h00, 8'h00, 8'h00, 8'h00};
    sacc_top dut_u (.clock(clock), .arst_n(arst_n), .sfr_addr(sfr_addr),
        .sfr_wr_en(sfr_wr_en), .sfr_wdata(sfr_wdata),
        .sfr_rdata_q(sfr_rdata_q), .timer2_ovf(timer2_ovf),
        .timer3_ovf(timer3_ovf), .ext_convert_start(ext_convert_start),
        .cmp_in(cmp_in), .chip_sleep(chip_sleep), .irq_en(irq_en),
        .conv_irq_q(conv_irq_q), .conv_busy_q(conv_busy_q),
        .analog_enable_q(analog_enable_q), .track_q(track_q),
        .sar_code_q(sar_code_q), .mux_channel_q(mux_channel_q),
        .mux_diff_q(mux_diff_q), .temp_sel_q(temp_sel_q), .gain_q(gain_q));
    sacc_partner part_u (.clock(clock), .sar_code_q(sar_code_q),
        .timer2_ovf(timer2_ovf), .timer3_ovf(timer3_ovf),
        .ext_convert_start(ext_convert_start), .cmp_in(cmp_in));
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    // ----
    // Helpers: expected values, bus cycles, comparison
    // ----
    function automatic logic [31:0] step(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // Differential codes flip the top bit into two's complement
    function automatic logic [15:0] res(input logic [11:0] t,
        input logic d, input logic l);
        logic [11:0] w;
        w = d ? {~t[11], t[10:0]} : t;
        return l ? {w, 4'h0} : {{4{d & w[11]}}, w};
    endfunction
    task automatic end_of_test();
        if (failures == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr_en = 1'b1;
        @(negedge clock);
        sfr_wr_en = 1'b0;
        // One idle edge keeps back-to-back writes as separate strobes
        @(negedge clock);
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        sfr_addr = a;
        @(negedge clock);
        d = sfr_rdata_q;
    endtask
    // Poll the done flag; a stuck conversion ends the run
    task automatic wait_done();
        n_len = 0;
        v = 8'h00;
        while (v[5] !== 1'b1) begin
            rd(8'hE8, v);
            n_len++;
            if (n_len > 400) begin
                failures++;
                end_of_test();
            end
        end
        chk(v[4], 1'b0);
    endtask
    task automatic conv(input logic [1:0] src, input logic [11:0] t);
        logic d;
        lfsr = step(lfsr);
        tm = lfsr[16];
        lj = lfsr[17];
        irq_en = lfsr[18];
        part_u.level = t;
        wr(8'hBA, lfsr[7:0]);
        wr(8'hBB, lfsr[15:8] & 8'hF7);
        d = lfsr[lfsr[10:9]];
        wr(8'hE8, {1'b1, tm, 2'b00, src, 1'b0, lj});
        repeat (40) @(negedge clock);
        rd(8'hBA, v);
        chk(v, {4'h0, lfsr[3:0]});
        chk({mux_diff_q, mux_channel_q}, {d, lfsr[10:9], lfsr[8] & !d});
        if (src == 2'h0) begin
            wr(8'hE8, {1'b1, tm, 2'b01, src, 1'b0, lj});
        end else if (src == 2'h2) begin
            part_u.pin(1'b0);
            repeat (10) @(negedge clock);
            chk(track_q, 1'b1);
            part_u.pin(1'b1);
        end else begin
            part_u.ovf(src == 2'h1);
        end
        wait_done();
        rd(8'hBF, hi);
        rd(8'hBE, v);
        chk({hi, v}, res(t, d, lj));
        chk({conv_irq_q, track_q}, {irq_en, !tm});
        repeat (260) @(negedge clock);
        rd(8'hE8, v);
        chk(v[5], 1'b1);
    endtask
    // ----
    // Main sequence
    // ----
    initial begin
        arst_n = 1'b0;
        sfr_wr_en = 1'b0;
        sfr_addr = 8'h00;
        sfr_wdata = 8'h00;
        chip_sleep = 1'b0;
        irq_en = 1'b1;
        lfsr = 32'h863B;
        failures = 0;
        total_checks = 0;
        repeat (8) @(negedge clock);
        arst_n = 1'b1;
        repeat (3) @(negedge clock);
        wr(8'h00, 8'h5A);
        foreach (ra[i]) begin
            rd(ra[i], v);
            chk(v, rv[i]);
        end
        wr(8'hBA, 8'h0F);
        wr(8'hBB, 8'h0F);
        repeat (3) @(negedge clock);
        chk({temp_sel_q, mux_diff_q}, 2'b10);
        wr(8'hBC, 8'h00);
        for (int i = 0; i < 8; i++) begin
            conv(i[1:0], i == 0 ? 12'hFFF : i == 1 ? 12'h000 : lfsr[31:20]);
            if (i == 0) n_fast = n_len;
        end
        wr(8'hE8, 8'h94);
        repeat (4) @(negedge clock);
        chk(conv_busy_q, 1'b0);
        part_u.ovf(1'b1);
        wait_done();
        part_u.ovf(1'b1);
        repeat (4) @(negedge clock);
        chk(conv_busy_q, 1'b0);
        wr(8'hE8, 8'h94);
        repeat (228) @(negedge clock);
        part_u.ovf(1'b1);
        repeat (2) @(negedge clock);
        chk(conv_busy_q, 1'b1);
        wait_done();
        repeat (260) @(negedge clock);
        wr(8'hE8, 8'h80);
        chip_sleep = 1'b1;
        repeat (3) @(negedge clock);
        chk(track_q, 1'b0);
        chip_sleep = 1'b0;
        repeat (3) @(negedge clock);
        chk(track_q, 1'b1);
        wr(8'hE8, 8'h10);
        repeat (4) @(negedge clock);
        chk({analog_enable_q, conv_busy_q, track_q}, 3'h0);
        wr(8'hBC, 8'h13);
        conv(2'h0, 12'h5A3);
        chk(gain_q, 3'h3);
        chk(n_len > n_fast + 11, 1'b1);
        end_of_test();
    end
endmodule // tb
`default_nettype wire
